// ==== rtl/rtcc_core.v ====
// control core of a battery-backed clock: oscillator control, divider
// chain, periodic/alarm/update interrupts, banked storage via index/data.
// assumes host strobes are synchronous to CORE_CLK; supply levels are async.
`timescale 1ns/100ps
`include "rtcc_defines.vh"
module rtcc_core (
  input  wire       CORE_CLK,
  input  wire       RST,
  input  wire       POR,
  input  wire       MAIN_SUPPLY_OK,
  input  wire       BATTERY_OK,
  input  wire       ALARM_MATCH,
  input  wire       HOST_SEL,
  input  wire       HOST_WR,
  input  wire       HOST_RD,
  input  wire [7:0] HOST_WDATA,
  output reg  [7:0] HOST_RDATA,
  output reg        HOST_RVALID,
  output reg        CLOCK_INTERRUPT_REQUEST_N,
  output reg        OSC_RUN
);
  // integer counts cut to their counter widths on purpose
  localparam integer TICK_LAST_I  = `RTCC_TICK_DIV - 1;
  localparam integer UIP_TICKS_I  = `RTCC_UIP_TICKS;
  localparam integer ALARM_LAST_I = `RTCC_ALARM_TICKS - 1;
  localparam [9:0]  TICK_LAST  = TICK_LAST_I[9:0];
  localparam [14:0] UIP_TICKS  = UIP_TICKS_I[14:0];
  localparam [14:0] UIP_FROM   = 15'h0 - UIP_TICKS;
  localparam [1:0]  ALARM_LAST = ALARM_LAST_I[1:0];

  wire       any_rst;
  wire       main_ok;
  wire       batt_ok;

  reg  [2:0] mode;
  reg  [3:0] rate;
  reg        update_pending_bit;
  reg        set_mode;
  reg        data_mode;
  reg        hour_mode;
  reg        dst_en;
  reg  [2:0] enables;
  reg  [2:0] flags;
  reg  [2:0] pend;
  reg  [6:0] index;
  reg  [6:0] uaddr;
  reg        valid_data_bit;
  reg        valid_seen;
  reg  [9:0] pre_cnt;
  reg        tick;
  reg [14:0] chain;
  reg        alarm_wait;
  reg  [1:0] alarm_cnt;
  reg  [7:0] mem [0:`RTCC_MEM_DEPTH-1];

  assign any_rst = RST | POR;

  // level inputs from the supply comparators
  rtcc_sync3 u_main_sync (
    .clk (CORE_CLK),
    .rst (any_rst),
    .d   (MAIN_SUPPLY_OK),
    .q   (main_ok)
  );

  rtcc_sync3 u_batt_sync (
    .clk (CORE_CLK),
    .rst (any_rst),
    .d   (BATTERY_OK),
    .q   (batt_ok)
  );

  // mode decode
  wire       chain_hold = (mode[2:1] == 2'b11);
  wire       running    = OSC_RUN & ~chain_hold;
  reg  [1:0] bank;

  always @* begin
    case (mode)
      `RTCC_MODE_BANK1: bank = 2'd1;
      `RTCC_MODE_BANK2: bank = 2'd2;
      default:          bank = 2'd0;
    endcase
  end

  wire next_osc = main_ok | (batt_ok & (mode[2:1] != 2'b00));

  wire acc_ok = main_ok;
  wire wr_idx = HOST_WR & ~HOST_SEL & acc_ok;
  wire wr_dat = HOST_WR & HOST_SEL & acc_ok & valid_data_bit;
  wire rd_dat = HOST_RD & HOST_SEL & acc_ok;

  reg  [3:0] tap;
  always @* begin
    case (rate)
      4'h1:    tap = 4'd7;
      4'h2:    tap = 4'd8;
      default: tap = rate - 4'd1;
    endcase
  end

  wire [14:0] period   = 15'h1 << tap;
  wire [14:0] half     = period >> 1;
  wire [14:0] phase    = chain + UIP_TICKS + half;
  wire [14:0] tap_mask = period - 15'h1;

  wire update_ev = tick & running & (chain == `RTCC_CHAIN_LAST);
  // periodic offset by half plus lead
  wire per_ev = tick & running & (rate != 4'h0) &
                ((phase & tap_mask) == 15'h0);
  wire alarm_ev = tick & running & alarm_wait & (alarm_cnt == ALARM_LAST);

  wire [2:0] events = {per_ev, alarm_ev, update_ev};

  wire clr_rd = rd_dat & (index == `RTCC_IDX_FLAGS);

  // sticky flags, repeats dropped; set beats clear
  wire [2:0] next_flags = (clr_rd ? 3'b000 : flags) | events;
  wire [2:0] next_pend  = ((clr_rd ? 3'b000 : pend) | (events & enables))
                          & enables;
  wire req_status = |(enables & flags);

  reg  [8:0] mem_addr;
  always @* begin
    if (index[6]) begin
      mem_addr = {1'b0, bank + 2'd1, index[5:0]};
    end else begin
      mem_addr = {3'b000, index[5:0]};
    end
  end

  wire is_uaddr = (bank == 2'd1) & (index == `RTCC_IDX_URAM_ADDR);
  wire is_udata = (bank == 2'd1) & (index == `RTCC_IDX_URAM_DATA);
  wire [8:0] uram_addr = {2'b10, uaddr};

  reg  [7:0] loc_data;
  always @* begin
    case (index)
      `RTCC_IDX_CTRL_A:
        loc_data = {update_pending_bit & ~set_mode, mode, rate};
      `RTCC_IDX_CTRL_B:
        loc_data = {set_mode, enables, 1'b0, data_mode, hour_mode, dst_en};
      `RTCC_IDX_FLAGS:
        loc_data = {req_status, flags, 4'h0};
      `RTCC_IDX_VALID:
        loc_data = {valid_data_bit, 7'h00};
      default: begin
        if (is_uaddr) begin
          loc_data = {1'b0, uaddr};
        end else if (is_udata) begin
          loc_data = mem[uram_addr];
        end else begin
          loc_data = mem[mem_addr];
        end
      end
    endcase
  end

  wire ctl_loc = (index >= `RTCC_IDX_CTRL_A) & (index <= `RTCC_IDX_VALID);

  always @(posedge CORE_CLK or posedge POR) begin
    if (POR) begin
      mode      <= `RTCC_MODE_RESET;
      rate      <= `RTCC_RATE_RESET;
      update_pending_bit       <= 1'b0;
      set_mode  <= 1'b0;
      data_mode <= 1'b0;
      hour_mode <= 1'b0;
      dst_en    <= 1'b0;
    end else begin
      update_pending_bit <= running & (chain >= UIP_FROM);
      if (wr_dat & (index == `RTCC_IDX_CTRL_A) & valid_seen) begin
        mode <= HOST_WDATA[`RTCC_MODE_MSB:`RTCC_MODE_LSB];
        rate <= HOST_WDATA[`RTCC_RATE_MSB:`RTCC_RATE_LSB];
      end
      if (wr_dat & (index == `RTCC_IDX_CTRL_B)) begin
        set_mode  <= HOST_WDATA[`RTCC_SET_BIT];
        data_mode <= HOST_WDATA[`RTCC_DM_BIT];
        hour_mode <= HOST_WDATA[`RTCC_HM_BIT];
        dst_en    <= HOST_WDATA[`RTCC_DSE_BIT];
      end
    end
  end

  // cleared by any reset
  always @(posedge CORE_CLK or posedge any_rst) begin
    if (any_rst) begin
      enables                   <= 3'b000;
      flags                     <= 3'b000;
      pend                      <= 3'b000;
      CLOCK_INTERRUPT_REQUEST_N <= 1'b1;
      OSC_RUN                   <= 1'b0;
      index                     <= 7'h00;
      uaddr                     <= 7'h00;
      valid_data_bit            <= 1'b0;
      valid_seen                <= 1'b0;
      HOST_RDATA                <= 8'h00;
      HOST_RVALID               <= 1'b0;
    end else begin
      OSC_RUN <= next_osc;
      flags   <= next_flags;
      pend    <= next_pend;
      CLOCK_INTERRUPT_REQUEST_N <= ~|next_pend;
      if (wr_idx) begin
        index <= HOST_WDATA[6:0];
      end
      if (wr_dat & (index == `RTCC_IDX_CTRL_B)) begin
        enables <= {HOST_WDATA[`RTCC_PIE_BIT], HOST_WDATA[`RTCC_AIE_BIT],
                    HOST_WDATA[`RTCC_UIE_BIT]};
      end
      if (wr_dat & is_uaddr) begin
        uaddr <= HOST_WDATA[6:0];
      end
      // battery loss invalidates; a read revalidates if battery is good
      if (~batt_ok) begin
        valid_data_bit <= 1'b0;
      end else if (rd_dat & (index == `RTCC_IDX_VALID)) begin
        valid_data_bit <= 1'b1;
      end
      if (rd_dat & (index == `RTCC_IDX_VALID)) begin
        valid_seen <= 1'b1;
      end
      HOST_RVALID <= HOST_RD & acc_ok;
      if (HOST_RD & acc_ok) begin
        HOST_RDATA <= HOST_SEL ? loc_data : {1'b0, index};
      end
    end
  end

  // time base and divider chain; stopped oscillator freezes the chain and drops a pending alarm, prescaler keeps counting
  always @(posedge CORE_CLK or posedge any_rst) begin
    if (any_rst) begin
      pre_cnt    <= 10'h000;
      tick       <= 1'b0;
      chain      <= `RTCC_CHAIN_START;
      alarm_wait <= 1'b0;
      alarm_cnt  <= 2'b00;
    end else begin
      tick <= 1'b0;
      if (pre_cnt == TICK_LAST) begin
        pre_cnt <= 10'h000;
        tick    <= 1'b1;
      end else begin
        pre_cnt <= pre_cnt + 10'h001;
      end
      // held chain restarts half a second before the first update
      if (tick & OSC_RUN) begin
        if (chain_hold) begin
          chain <= `RTCC_CHAIN_START;
        end else begin
          chain <= chain + 15'h0001;
        end
      end
      if (update_ev & ALARM_MATCH) begin
        alarm_wait <= 1'b1;
        alarm_cnt  <= 2'b00;
      end else if (alarm_ev | ~running) begin
        alarm_wait <= 1'b0;
      end else if (tick & alarm_wait) begin
        alarm_cnt <= alarm_cnt + 2'b01;
      end
    end
  end

  // battery-backed storage: no reset on purpose, contents survive resets
  always @(posedge CORE_CLK) begin
    if (wr_dat & ~ctl_loc & ~is_uaddr) begin
      if (is_udata) begin
        mem[uram_addr] <= HOST_WDATA;
      end else begin
        mem[mem_addr] <= HOST_WDATA;
      end
    end
  end
endmodule

// ==== common/rtcc_defines.vh ====
// constants for the clock control core: register indexes, field places,
// reset values and timing counts; assumes a 25 MHz core clock.
`ifndef RTCC_DEFINES_VH
`define RTCC_DEFINES_VH

`define RTCC_CLK_HZ        25000000
`define RTCC_BASE_HZ       32768
`define RTCC_TICK_DIV      (`RTCC_CLK_HZ / `RTCC_BASE_HZ)
`define RTCC_TICK_NS       (1000000000 / `RTCC_BASE_HZ)
`define RTCC_UIP_LEAD_NS   244000
`define RTCC_UIP_TICKS     \
  ((`RTCC_UIP_LEAD_NS + `RTCC_TICK_NS - 1) / `RTCC_TICK_NS)
`define RTCC_ALARM_NS      30500
`define RTCC_ALARM_TICKS   \
  ((`RTCC_ALARM_NS + `RTCC_TICK_NS - 1) / `RTCC_TICK_NS)
`define RTCC_CHAIN_START   15'h4000
`define RTCC_CHAIN_LAST    15'h7fff

`define RTCC_IDX_CTRL_A    7'h0a
`define RTCC_IDX_CTRL_B    7'h0b
`define RTCC_IDX_FLAGS     7'h0c
`define RTCC_IDX_VALID     7'h0d
`define RTCC_IDX_URAM_ADDR 7'h50
`define RTCC_IDX_URAM_DATA 7'h53

`define RTCC_RATE_LSB      0
`define RTCC_RATE_MSB      3
`define RTCC_MODE_LSB      4
`define RTCC_MODE_MSB      6
`define RTCC_UIP_BIT       7
`define RTCC_SET_BIT       7
`define RTCC_PIE_BIT       6
`define RTCC_AIE_BIT       5
`define RTCC_UIE_BIT       4
`define RTCC_DM_BIT        2
`define RTCC_HM_BIT        1
`define RTCC_DSE_BIT       0
`define RTCC_REQ_BIT       7
`define RTCC_PF_BIT        6
`define RTCC_AF_BIT        5
`define RTCC_UF_BIT        4
`define RTCC_VALID_BIT     7

`define RTCC_MODE_RESET    3'h0
`define RTCC_RATE_RESET    4'h0
`define RTCC_MODE_BANK0    3'h2
`define RTCC_MODE_BANK1    3'h3
`define RTCC_MODE_BANK2    3'h4
`define RTCC_MEM_DEPTH     384

`endif

// ==== rtl/rtcc_sync3.v ====
// three-stage synchroniser with agreement filter for one level.
// assumes d is asynchronous to clk; q moves once stages two and three agree.
`timescale 1ns/100ps
module rtcc_sync3 (
  input  wire clk,
  input  wire rst,
  input  wire d,
  output reg  q
);
  reg s1;
  reg s2;
  reg s3;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q  <= 1'b0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end
endmodule

// ==== tb/rtcc_sva.sv ====
// checker for rtcc_core: host answers, lockout, request line, oscillator
// assumes binding onto rtcc_core; host strobes are one-cycle pulses
`timescale 1ns/100ps
module rtcc_sva (
  input wire       CORE_CLK,
  input wire       RST,
  input wire       POR,
  input wire       MAIN_SUPPLY_OK,
  input wire       HOST_SEL,
  input wire       HOST_WR,
  input wire       HOST_RD,
  input wire [7:0] HOST_WDATA,
  input wire [7:0] HOST_RDATA,
  input wire       HOST_RVALID,
  input wire       CLOCK_INTERRUPT_REQUEST_N,
  input wire       OSC_RUN
);
  reg  [6:0] idx = 7'h00;
  wire       rd_flags;
  // comparator level unsynced here, so bench keeps reads clear of edges
  assign rd_flags = HOST_RD && HOST_SEL && MAIN_SUPPLY_OK && idx == 7'h0c;
  always @(posedge CORE_CLK)
    if (HOST_WR && !HOST_SEL)
      idx <= HOST_WDATA[6:0];
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST || POR);
  a_answer_delay: assert property (
    HOST_RVALID |-> $past(HOST_RD))
    else $error("read answer without read strobe");
  a_write_silent: assert property (
    HOST_WR && !HOST_RD |=> !HOST_RVALID)
    else $error("write produced a read answer");
  a_lockout_read: assert property (
    !MAIN_SUPPLY_OK [*6] ##0 HOST_RD |=> !HOST_RVALID)
    else $error("read answered while supply absent");
  a_flags_clear: assert property (
    rd_flags |=> CLOCK_INTERRUPT_REQUEST_N)
    else $error("request still low after flag read");
  a_flag_reserved: assert property (
    HOST_RVALID && $past(rd_flags) |-> HOST_RDATA[3:0] == 4'h0)
    else $error("flag register low bits not zero");
  a_irq_status: assert property (
    HOST_RVALID && $past(rd_flags) &&
    !$past(CLOCK_INTERRUPT_REQUEST_N) |-> HOST_RDATA[7])
    else $error("status bit low while request active");
  a_irq_holds: assert property (
    !CLOCK_INTERRUPT_REQUEST_N && !HOST_WR && !HOST_RD &&
    !$past(HOST_WR) |=> !CLOCK_INTERRUPT_REQUEST_N)
    else $error("request released without host action");
  a_osc_on: assert property (
    MAIN_SUPPLY_OK [*8] |-> OSC_RUN)
    else $error("oscillator stopped with supply present");
  c_irq: cover property ($fell(CLOCK_INTERRUPT_REQUEST_N));
  c_flag_read: cover property (rd_flags);
  c_locked_read: cover property (!MAIN_SUPPLY_OK && HOST_RD);
endmodule
bind rtcc_core rtcc_sva i_sva (.CORE_CLK(CORE_CLK), .RST(RST), .POR(POR),
  .MAIN_SUPPLY_OK(MAIN_SUPPLY_OK), .HOST_SEL(HOST_SEL), .HOST_WR(HOST_WR),
  .HOST_RD(HOST_RD), .HOST_WDATA(HOST_WDATA), .HOST_RDATA(HOST_RDATA),
  .HOST_RVALID(HOST_RVALID), .OSC_RUN(OSC_RUN),
  .CLOCK_INTERRUPT_REQUEST_N(CLOCK_INTERRUPT_REQUEST_N));

// ==== tb/rtcc_host.sv ====
// host model for rtcc_core: index/data port strobes
// assumes clk is CORE_CLK; changes launch on the falling edge
`timescale 1ns/100ps
module rtcc_host (
  input  wire       clk,
  output reg        sel,
  output reg        wr,
  output reg        rd,
  output reg  [7:0] wdata
);
  initial begin
    sel = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  // idle data is inverted so a stale byte never looks valid
  task xfer(input s, input w, input [7:0] v);
    begin
      @(negedge clk);
      sel <= s;
      wr <= w;
      rd <= !w;
      wdata <= v;
      @(negedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      wdata <= ~v;
    end
  endtask
  task access(input [6:0] idx, input w, input [7:0] v);
    begin
      xfer(1'b0, 1'b1, {1'b0, idx});
      xfer(1'b1, w, v);
    end
  endtask
endmodule

// ==== tb/rtcc_core_test.sv ====
// self-checking bench for rtcc_core: registers, flags, banks, lockout
// assumes rtcc_host drives the host port and rtcc_sva is bound in
`timescale 1ns/100ps
module rtcc_core_test;
  reg        CORE_CLK;
  reg        RST;
  reg        POR;
  reg        MAIN_SUPPLY_OK;
  reg        BATTERY_OK;
  reg        ALARM_MATCH;
  wire       HOST_SEL;
  wire       HOST_WR;
  wire       HOST_RD;
  wire [7:0] HOST_WDATA;
  wire [7:0] HOST_RDATA;
  wire       HOST_RVALID;
  wire       CLOCK_INTERRUPT_REQUEST_N;
  wire       OSC_RUN;
  integer    errors;
  integer    checks;
  integer    n;
  reg  [7:0] d;
  reg  [7:0] exp_q[$];
  reg  [7:0] msk_q[$];

  rtcc_core i_dut (.CORE_CLK(CORE_CLK), .RST(RST), .POR(POR),
    .MAIN_SUPPLY_OK(MAIN_SUPPLY_OK), .BATTERY_OK(BATTERY_OK),
    .ALARM_MATCH(ALARM_MATCH), .HOST_SEL(HOST_SEL), .HOST_WR(HOST_WR),
    .HOST_RD(HOST_RD), .HOST_WDATA(HOST_WDATA), .HOST_RDATA(HOST_RDATA),
    .HOST_RVALID(HOST_RVALID), .OSC_RUN(OSC_RUN),
    .CLOCK_INTERRUPT_REQUEST_N(CLOCK_INTERRUPT_REQUEST_N));
  rtcc_host i_host (.clk(CORE_CLK), .sel(HOST_SEL), .wr(HOST_WR),
    .rd(HOST_RD), .wdata(HOST_WDATA));

  initial begin
    CORE_CLK = 1'b0;
    forever #20 CORE_CLK = ~CORE_CLK;
  end

  task test_done;
    begin
      if (errors == 0 && checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] want, input [7:0] msk);
    begin
      checks = checks + 1;
      if ((got & msk) !== (want & msk)) begin
        errors = errors + 1;
        $display("BAD %0t read %h want %h", $time, got, want);
      end
    end
  endtask
  task chk_bit(input got, input want);
    begin
      checks = checks + 1;
      if (got !== want) begin
        errors = errors + 1;
        $display("BAD %0t level %b want %b", $time, got, want);
      end
    end
  endtask
  task r(input [6:0] idx, input [7:0] want, input [7:0] msk);
    begin
      exp_q.push_back(want);
      msk_q.push_back(msk);
      i_host.access(idx, 1'b0, 8'h00);
    end
  endtask
  task w(input [6:0] idx, input [7:0] v);
    i_host.access(idx, 1'b1, v);
  endtask
  task wait_irq(input integer lim);
    begin
      n = 0;
      while (CLOCK_INTERRUPT_REQUEST_N !== 1'b0 && n < lim) begin
        @(negedge CORE_CLK);
        n = n + 1;
      end
    end
  endtask

  always @(negedge CORE_CLK)
    if (HOST_RVALID === 1'b1) begin
      if (exp_q.size() == 0)
        chk_bit(1'b1, 1'b0);
      else
        chk(HOST_RDATA, exp_q.pop_front(), msk_q.pop_front());
    end

  initial begin
    repeat (60000) @(posedge CORE_CLK);
    errors = errors + 1;
    test_done;
  end

  initial begin
    errors = 0;
    checks = 0;
    RST = 1'b1;
    POR = 1'b1;
    MAIN_SUPPLY_OK = 1'b1;
    BATTERY_OK = 1'b1;
    d = $urandom(32'hbb45);
    ALARM_MATCH = d[0];
    repeat (6) @(negedge CORE_CLK);
    RST = 1'b0;
    POR = 1'b0;
    repeat (8) @(negedge CORE_CLK);
    r(7'h0d, 8'h00, 8'hff);
    r(7'h0d, 8'h80, 8'hff);
    w(7'h0a, 8'h23);
    r(7'h0a, 8'h23, 8'h7f);
    d = $urandom;
    w(7'h20, d);
    w(7'h60, ~d);
    w(7'h0a, 8'h33);
    r(7'h0a, 8'h33, 8'h7f);
    w(7'h60, d);
    r(7'h20, d, 8'hff);
    r(7'h60, d, 8'hff);
    w(7'h50, 8'h11);
    w(7'h53, ~d);
    w(7'h50, 8'h12);
    w(7'h53, d);
    w(7'h50, 8'h11);
    r(7'h53, ~d, 8'hff);
    w(7'h0a, 8'h23);
    r(7'h60, ~d, 8'hff);
    w(7'h0b, 8'h40);
    r(7'h0c, 8'h00, 8'h0f);
    wait_irq(3500);
    chk_bit(CLOCK_INTERRUPT_REQUEST_N, 1'b0);
    repeat (6200) @(negedge CORE_CLK);
    r(7'h0c, 8'hc0, 8'hff);
    r(7'h0c, 8'h00, 8'hff);
    chk_bit(CLOCK_INTERRUPT_REQUEST_N, 1'b1);
    w(7'h0b, 8'h00);
    r(7'h0c, 8'h00, 8'h0f);
    repeat (3500) @(negedge CORE_CLK);
    w(7'h0b, 8'h40);
    chk_bit(CLOCK_INTERRUPT_REQUEST_N, 1'b1);
    r(7'h0c, 8'hc0, 8'hff);
    // held divider chain: no periodic event, then half period on release
    w(7'h0a, 8'h63);
    r(7'h0c, 8'h00, 8'h0f);
    repeat (3100) @(negedge CORE_CLK);
    chk_bit(CLOCK_INTERRUPT_REQUEST_N, 1'b1);
    r(7'h0c, 8'h00, 8'hff);
    w(7'h0a, 8'h23);
    wait_irq(3500);
    chk_bit(n > 1400 && n < 2400, 1'b1);
    r(7'h0c, 8'hc0, 8'hff);
    RST = 1'b1;
    repeat (2) @(negedge CORE_CLK);
    RST = 1'b0;
    repeat (8) @(negedge CORE_CLK);
    chk_bit(CLOCK_INTERRUPT_REQUEST_N, 1'b1);
    r(7'h0a, 8'h23, 8'h7f);
    w(7'h20, ~d);
    r(7'h20, d, 8'hff);
    r(7'h0d, 8'h00, 8'hff);
    r(7'h0d, 8'h80, 8'hff);
    w(7'h0a, 8'h03);
    chk_bit(OSC_RUN, 1'b1);
    MAIN_SUPPLY_OK = 1'b0;
    repeat (8) @(negedge CORE_CLK);
    chk_bit(OSC_RUN, 1'b0);
    i_host.access(7'h20, 1'b0, 8'h00);
    MAIN_SUPPLY_OK = 1'b1;
    repeat (8) @(negedge CORE_CLK);
    r(7'h0a, 8'h03, 8'h7f);
    // normal mode keeps running on battery; low battery stops and invalidates
    w(7'h0a, 8'h23);
    MAIN_SUPPLY_OK = 1'b0;
    repeat (8) @(negedge CORE_CLK);
    chk_bit(OSC_RUN, 1'b1);
    BATTERY_OK = 1'b0;
    repeat (8) @(negedge CORE_CLK);
    chk_bit(OSC_RUN, 1'b0);
    MAIN_SUPPLY_OK = 1'b1;
    repeat (8) @(negedge CORE_CLK);
    r(7'h0d, 8'h00, 8'hff);
    w(7'h20, ~d);
    r(7'h20, d, 8'hff);
    BATTERY_OK = 1'b1;
    repeat (4) @(negedge CORE_CLK);
    chk_bit(exp_q.size() == 0, 1'b1);
    test_done;
  end
endmodule
